// ==== bench/ssp_board_model.sv ====
`timescale 1ns/100ps
// board side of the two shared pins: strap resistors plus the device drivers resolved onto each wire
module ssp_board_model (
  input  wire logic gang_strap,
  input  wire logic auto_strap,
  input  wire logic link_oe_n,
  input  wire logic link_drv,
  input  wire logic susp_oe_n,
  input  wire logic susp_drv,
  output logic      link_wire,
  output logic      susp_wire
);
  // resistor level wins only while the device leaves the pin as an input
  assign link_wire = link_oe_n ? gang_strap : link_drv;
  assign susp_wire = susp_oe_n ? auto_strap : susp_drv;
endmodule : ssp_board_model

// ==== bench/tb_strap_and_status_pins.sv ====
`timescale 1ns/100ps
module tb_strap_and_status_pins;
  import ssp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, hs_conn, hs_susp, hub_conn, gang_s, auto_s;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, link_st, link_oe_n, susp_st, susp_oe_n, gang_sel;
  logic        link_w, susp_w;
  logic [3:0]  acm_en, cdp_ok;
  logic [32:0] exp_q[$], msk_q[$];
  logic [32:0] st_exp;
  int          bad_count = 0, total_checks = 0, cycles = 0, seed_val;

  always #2.5 pclk = ~pclk;

  ssp_strap_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .upstream_hs_connected(hs_conn), .upstream_hs_suspended(hs_susp),
    .hub_connected(hub_conn), .link_pin_in(link_w), .upstream_highspeed_link_status(link_st),
    .link_pin_oe_n(link_oe_n), .auto_charge_mode_strap_n(susp_w),
    .upstream_highspeed_suspend_status(susp_st), .susp_pin_oe_n(susp_oe_n),
    .ganged_power_sel(gang_sel), .auto_charge_en(acm_en), .cdp_allowed(cdp_ok));

  ssp_board_model u_board (.gang_strap(gang_s), .auto_strap(auto_s), .link_oe_n(link_oe_n),
    .link_drv(link_st), .susp_oe_n(susp_oe_n), .susp_drv(susp_st), .link_wire(link_w),
    .susp_wire(susp_w));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic cmp_read(logic [32:0] got, logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_read

  task automatic cmp_pin(logic [3:0] got, logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_pin

  // apb master; reads note {pslverr, prdata} expectation under a mask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e, logic [32:0] m);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // straps held through reset, then flipped: captured values must not follow
  task automatic do_reset(logic g, logic a);
    @(posedge pclk);
    presetn <= 1'b0;
    gang_s  <= g;
    auto_s  <= a;
    repeat (5) @(posedge pclk);
    cmp_pin({2'b0, link_oe_n, susp_oe_n}, 4'h3);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    gang_s <= ~g;
    auto_s <= ~a;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // monitor: read result is sampled at the completing edge
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      cmp_read({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());

  // hang guard, generous against about 260 cycles of real work
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, hs_conn, hs_susp, hub_conn, gang_s, auto_s} = '0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    seed_val = $urandom(7);
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1], i[0]);
      apb(1'b0, SSP_STATUS_OFS, 32'h0, {31'h1, i[1:0]}, 33'h7);
      cmp_pin({3'b0, gang_sel}, {3'b0, i[1]});
      apb(1'b0, SSP_BATT_OFS, 32'h0, {32'h0, i[0]}, 33'h1);
      cmp_pin({2'b0, link_oe_n, susp_oe_n}, 4'h3);
      apb(1'b1, SSP_CTRL_OFS, 32'h3, 33'h0, 33'h0);
      // random link states must show on the pins one cycle later
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        hs_conn <= 1'($urandom);
        hs_susp <= 1'($urandom);
        repeat (2) @(posedge pclk);
        cmp_pin({2'b0, link_oe_n, link_st}, {3'b0, hs_conn});
        cmp_pin({2'b0, susp_oe_n, susp_st}, {3'b0, hs_susp});
      end
      // both enables read back, and status shows the strap copy and both drivers
      st_exp = {27'h0, 2'b11, ~i[0], 1'b1, i[1], i[0]};
      apb(1'b0, SSP_CTRL_OFS, 32'h0, 33'h3, 33'h1_ffff_ffff);
      apb(1'b0, SSP_STATUS_OFS, 32'h0, st_exp, 33'h1_ffff_ffff);
      // every mix of auto-mode bit and host presence, all ports enabled
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, SSP_BATT_OFS, {27'h0, 4'hf, m[1]}, 33'h0, 33'h0);
        hub_conn <= m[0];
        repeat (2) @(posedge pclk);
        cmp_pin(acm_en, (m == 0) ? 4'hf : 4'h0);
        cmp_pin(cdp_ok, !m[0] ? 4'h0 : (m[1] ? 4'hf : 4'he));
      end
      // suspend pin alone: the link pin must fall back to an input
      apb(1'b1, SSP_CTRL_OFS, 32'h2, 33'h0, 33'h0);
      repeat (2) @(posedge pclk);
      cmp_pin({2'b0, link_oe_n, susp_oe_n}, 4'h2);
      apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0}, 33'h1_ffff_ffff);
    end
    repeat (3) @(posedge pclk);
    // a read whose answer never showed counts as a miss
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("ERROR t=%0t reads left got=%h exp=%h", $time, exp_q.size(), 0);
    end
    print_verdict();
  end
endmodule : tb_strap_and_status_pins

// ==== src/ssp_pkg.sv ====
package ssp_pkg;
  // apb register byte offsets
  localparam logic [7:0] SSP_CTRL_OFS     = 8'h00;
  localparam logic [7:0] SSP_STATUS_OFS   = 8'h04;
  localparam logic [7:0] SSP_BATT_OFS     = 8'h08;
  // ctrl fields (additional feature configuration)
  localparam int         SSP_CTRL_LINK_EN = 0;
  localparam int         SSP_CTRL_SUSP_EN = 1;
  // battery charging support fields
  localparam int         SSP_BATT_AUTO    = 0;
  localparam int         SSP_BATT_PORT_LO = 1;
  // status fields
  localparam int         SSP_ST_AUTO_STRAP = 0;
  localparam int         SSP_ST_GANG_STRAP = 1;
  localparam int         SSP_ST_DONE       = 2;
  localparam int         SSP_ST_AUTO_MODE  = 3;
  localparam int         SSP_ST_LINK_DRV   = 4;
  localparam int         SSP_ST_SUSP_DRV   = 5;
  // reset values and port count
  localparam logic       SSP_LINK_EN_RST  = 1'b0;
  localparam logic       SSP_SUSP_EN_RST  = 1'b0;
  localparam logic       SSP_AUTO_DIS_RST = 1'b1;
  localparam int         SSP_NUM_PORTS    = 4;
endpackage : ssp_pkg

// ==== src/ssp_strap_if.sv ====
`timescale 1ns/100ps
// carries the shared pin levels to the strap latch and the captured straps back
interface ssp_strap_if;
  logic auto_pin;
  logic gang_pin;
  logic done;
  logic auto_n;
  logic gang;
  modport latch (input auto_pin, input gang_pin, output done, output auto_n, output gang);
  modport user  (output auto_pin, output gang_pin, input done, input auto_n, input gang);
endinterface : ssp_strap_if

// ==== src/ssp_strap_latch.sv ====
`timescale 1ns/100ps
module ssp_strap_latch (
  input  wire logic  pclk,
  input  wire logic  presetn,
  ssp_strap_if.latch sif
);
  import ssp_pkg::*;

  typedef struct packed {
    logic done;
    logic auto_n;
    logic gang;
  } ssp_latch_state_t;

  ssp_latch_state_t s_q;
  ssp_latch_state_t s_d;

  // async reset may only load constants, so the straps are taken at the
  // first edge after release, while the shared pins are still inputs
  always_comb begin
    s_d = s_q;
    if (!s_q.done) begin
      s_d.done   = 1'b1;
      s_d.auto_n = sif.auto_pin;
      s_d.gang   = sif.gang_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.done   = s_q.done;
  assign sif.auto_n = s_q.auto_n;
  assign sif.gang   = s_q.gang;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the release edge still finds the flops in reset, so capture is only
  // checked from the first edge at which presetn is sampled high
  a_auto_capture: assert property (presetn && !s_q.done |=>
    s_q.done && s_q.auto_n == $past(sif.auto_pin))
    else $error("auto strap not captured at reset release");
  a_strap_hold: assert property (s_q.done |=>
    $stable(s_q.auto_n) && $stable(s_q.gang))
    else $error("captured straps changed after capture");
  a_gang_capture: assert property (presetn && !s_q.done |=>
    s_q.gang == $past(sif.gang_pin))
    else $error("gang strap not captured at reset release");
  c_strap_taken: cover property ($rose(s_q.done));
endmodule : ssp_strap_latch

// ==== src/ssp_strap_status.sv ====
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module ssp_strap_status #(
  parameter int NUM_PORTS = ssp_pkg::SSP_NUM_PORTS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 upstream_hs_connected,
  input  wire logic                 upstream_hs_suspended,
  input  wire logic                 hub_connected,
  input  wire logic                 link_pin_in,
  output logic                      upstream_highspeed_link_status,
  output logic                      link_pin_oe_n,
  input  wire logic                 auto_charge_mode_strap_n,
  output logic                      upstream_highspeed_suspend_status,
  output logic                      susp_pin_oe_n,
  output logic                      ganged_power_sel,
  output logic [NUM_PORTS-1:0]      auto_charge_en,
  output logic [NUM_PORTS-1:0]      cdp_allowed
);
  import ssp_pkg::*;

  typedef struct packed {
    logic                 link_en;
    logic                 susp_en;
    logic                 auto_charge_mode_disable_bit;
    logic                 auto_loaded;
    logic [NUM_PORTS-1:0] bc_en;
    logic [31:0]          rdata;
    logic                 slverr;
    logic                 link_out;
    logic                 link_oe_n;
    logic                 susp_out;
    logic                 susp_oe_n;
  } ssp_main_state_t;

  ssp_main_state_t s_q;
  ssp_main_state_t s_d;
  ssp_strap_if     sif ();
  logic            auto_mode;
  logic            setup;
  logic            wr;
  logic            hit;
  logic [31:0]     rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture; the shared pins feed it while their drivers are off
  assign sif.auto_pin = auto_charge_mode_strap_n;
  assign sif.gang_pin = link_pin_in;

  ssp_strap_latch u_latch (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  assign ganged_power_sel = sif.done & sif.gang;

  ////////////////////////////////////////////////////////////////////////////
  // per-port charge mode; automatic mode only while the hub is unconnected
  assign auto_mode = sif.done & ~s_q.auto_charge_mode_disable_bit;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign auto_charge_en[p] = auto_mode & s_q.bc_en[p] & ~hub_connected;
    if (p == 0) begin : g_first
      // port 1 gives up cdp entirely whenever automatic mode is on
      assign cdp_allowed[p] = s_q.bc_en[p] & hub_connected & ~auto_mode;
    end else begin : g_rest
      assign cdp_allowed[p] = s_q.bc_en[p] & hub_connected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, read data latched in the setup cycle
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;
  assign hit   = (paddr == SSP_CTRL_OFS) | (paddr == SSP_STATUS_OFS) |
                 (paddr == SSP_BATT_OFS);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      SSP_CTRL_OFS: begin
        rd_val[SSP_CTRL_LINK_EN] = s_q.link_en;
        rd_val[SSP_CTRL_SUSP_EN] = s_q.susp_en;
      end
      SSP_STATUS_OFS: begin
        rd_val[SSP_ST_AUTO_STRAP] = sif.auto_n;
        rd_val[SSP_ST_GANG_STRAP] = sif.gang;
        rd_val[SSP_ST_DONE]       = sif.done;
        rd_val[SSP_ST_AUTO_MODE]  = auto_mode;
        rd_val[SSP_ST_LINK_DRV]   = ~s_q.link_oe_n;
        rd_val[SSP_ST_SUSP_DRV]   = ~s_q.susp_oe_n;
      end
      SSP_BATT_OFS: begin
        rd_val[SSP_BATT_AUTO] = s_q.auto_charge_mode_disable_bit;
        rd_val[SSP_BATT_PORT_LO +: NUM_PORTS] = s_q.bc_en;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: registers, strap load and pin drivers
  always_comb begin
    s_d = s_q;
    if (setup) begin
      s_d.rdata  = rd_val;
      s_d.slverr = ~hit;
    end
    if (wr && paddr == SSP_CTRL_OFS) begin
      s_d.link_en = pwdata[SSP_CTRL_LINK_EN];
      s_d.susp_en = pwdata[SSP_CTRL_SUSP_EN];
    end
    if (wr && paddr == SSP_BATT_OFS) begin
      s_d.auto_charge_mode_disable_bit = pwdata[SSP_BATT_AUTO];
      s_d.bc_en = pwdata[SSP_BATT_PORT_LO +: NUM_PORTS];
    end
    // the strap load wins over a software write landing in the same cycle
    if (sif.done && !s_q.auto_loaded) begin
      s_d.auto_loaded                  = 1'b1;
      s_d.auto_charge_mode_disable_bit = sif.auto_n;
    end
    // drivers stay off until the straps are in, so a strap is never fought
    s_d.link_out  = upstream_hs_connected;
    s_d.link_oe_n = ~(sif.done & s_q.link_en);
    s_d.susp_out  = upstream_hs_suspended;
    s_d.susp_oe_n = ~(sif.done & s_q.susp_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                              <= '0;
      s_q.link_en                      <= SSP_LINK_EN_RST;
      s_q.susp_en                      <= SSP_SUSP_EN_RST;
      s_q.auto_charge_mode_disable_bit <= SSP_AUTO_DIS_RST;
      s_q.link_oe_n                    <= 1'b1;
      s_q.susp_oe_n                    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign pready                            = 1'b1;
  assign prdata                            = s_q.rdata;
  assign pslverr                           = s_q.slverr & psel & penable;
  assign upstream_highspeed_link_status    = s_q.link_out;
  assign link_pin_oe_n                     = s_q.link_oe_n;
  assign upstream_highspeed_suspend_status = s_q.susp_out;
  assign susp_pin_oe_n                     = s_q.susp_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // every check below lives in the pclk domain and is quiet during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pin drivers: nothing drives a shared pin before its strap is in
  a_link_enable: assert property (sif.done && s_q.link_en |=>
    !link_pin_oe_n)
    else $error("link status pin not driven when enabled");
  a_link_value: assert property (!link_pin_oe_n |->
    upstream_highspeed_link_status == $past(upstream_hs_connected))
    else $error("link status pin does not follow connection");
  a_susp_enable: assert property (sif.done && s_q.susp_en |=>
    !susp_pin_oe_n)
    else $error("suspend pin not driven when enabled");
  a_susp_value: assert property (!susp_pin_oe_n |->
    upstream_highspeed_suspend_status == $past(upstream_hs_suspended))
    else $error("suspend pin does not follow suspend state");
  a_pin_input: assert property (!sif.done |->
    link_pin_oe_n && susp_pin_oe_n ##1 link_pin_oe_n && susp_pin_oe_n)
    else $error("shared pin driven before strap capture");
  a_link_gate: assert property (!link_pin_oe_n |->
    $past(sif.done) && $past(s_q.link_en))
    else $error("link status pin driven without strap or enable");
  a_susp_gate: assert property (!susp_pin_oe_n |->
    $past(sif.done) && $past(s_q.susp_en))
    else $error("suspend pin driven without strap or enable");

  // strap copy and charge-mode decode
  a_auto_load: assert property ($rose(sif.done) |=>
    s_q.auto_charge_mode_disable_bit == sif.auto_n)
    else $error("auto-mode bit not loaded from strap");
  a_auto_off: assert property (s_q.auto_charge_mode_disable_bit |->
    auto_charge_en == '0)
    else $error("automatic charge mode active while disabled");
  a_auto_unconn: assert property (hub_connected |->
    auto_charge_en == '0)
    else $error("automatic charge mode active while connected");
  a_auto_on: assert property (auto_mode && !hub_connected |->
    auto_charge_en == s_q.bc_en)
    else $error("automatic charge mode missing on an enabled port");
  a_port1_cdp: assert property (auto_mode |->
    !cdp_allowed[0])
    else $error("port 1 cdp offered in automatic mode");

  // power control follows the captured gang strap
  a_gang_sel: assert property (sif.done |->
    ganged_power_sel == sif.gang)
    else $error("power control mode does not match strap");

  // main scenarios, each expected at least once per run
  c_link_drive: cover property (!link_pin_oe_n && upstream_highspeed_link_status);
  c_susp_drive: cover property (!susp_pin_oe_n && upstream_highspeed_suspend_status);
  c_auto_charge: cover property (auto_charge_en != '0);
  c_bad_addr: cover property (pslverr);
endmodule : ssp_strap_status
